// [hw/sac_top.sv]
/*
 * Serial control port of a 10-bit, 8-input sampling converter.
 * Assumes the host drives chip select, shift clock and serial input,
 * that the conversion clock is a free-running pin, and that the analog
 * core presents an offset-binary code for the selected input.
 */
`timescale 1ns/1ps
module sac_top
	import sac_pkg::*;
#(
	parameter int unsigned CONV_CYCLES    = SAC_CONV_ACLK,
	parameter int unsigned DEGLITCH_FALLS = SAC_DEGLITCH_FL
) (
	// clock and reset
	input  wire logic                    clock_in,
	input  wire logic                    nrst_in,
	// serial pins
	input  wire logic                    cs_n_in,
	input  wire logic                    sclk_in,
	input  wire logic                    din_in,
	input  wire logic                    aclk_in,
	output logic                         dout_out,
	output logic                         dout_oe_out,
	// analog core
	input  wire logic [SAC_RES_BITS-1:0] analog_code_in,
	output logic [2:0]                   pos_channel_out,
	output logic [2:0]                   neg_channel_out,
	output logic                         neg_is_common_out,
	output logic                         coding_select_out,
	output logic                         converting_out
);
	if (DEGLITCH_FALLS < 1 || DEGLITCH_FALLS > 3) begin : g_chk
		$error("sac_top: DEGLITCH_FALLS out of range");
	end

	localparam logic [1:0] DG_LAST = 2'(DEGLITCH_FALLS - 1);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// output length from the two length bits
	function automatic logic [SAC_CNT_W-1:0] word_len(input logic [1:0] wl);
		case (wl)
			2'h0:    word_len = SAC_LEN_8;
			2'h1:    word_len = SAC_LEN_10;
			2'h2:    word_len = SAC_LEN_12;
			default: word_len = SAC_LEN_16;
		endcase
	endfunction

	// outgoing word, first bit at the top, zeros padding the tail
	function automatic logic [SAC_OUT_MAX-1:0] out_word(
		input logic [SAC_RES_BITS-1:0] res,
		input logic                    high_bit_first_select);
		logic [SAC_RES_BITS-1:0] rev;
		rev = '0;
		for (int i = 0; i < SAC_RES_BITS; i++) begin
			rev[i] = res[SAC_RES_BITS-1-i];
		end
		out_word = {(high_bit_first_select ? res : rev), 6'h00};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]              cs_sync;
		logic [1:0]              sclk_sync;
		logic [1:0]              din_sync;
		logic [1:0]              aclk_sync;
		logic                    sclk_prev;
		logic                    aclk_prev;
		logic                    cs_rec;   // recognised pin level
		logic [1:0]              dg_cnt;
		logic                    loaded;   // output word in place
		logic                    done;     // exchange finished
		logic [SAC_CNT_W-1:0]    bit_cnt;
		logic [SAC_CFG_BITS-1:0] cfg;
		logic [SAC_CFG_BITS-1:0] req;      // config of running request
		logic                    high_bit_first_select_next;
		logic [SAC_OUT_MAX-1:0]  out_sh;
		logic                    start;
		logic                    aclk_fall;
	} sac_top_st_t;

	sac_top_st_t q_ff;
	sac_top_st_t nxt_q;

	sac_conv_if cv ();

	logic                    sclk_rise;
	logic                    sclk_fall;
	logic [SAC_CFG_BITS-1:0] cfg_new;
	logic [SAC_CNT_W-1:0]    cnt_new;

	// edges are seen only after both synchroniser stages
	assign sclk_rise = q_ff.sclk_sync[1] & ~q_ff.sclk_prev;
	assign sclk_fall = ~q_ff.sclk_sync[1] & q_ff.sclk_prev;
	assign cnt_new   = q_ff.bit_cnt + 5'h01;
	assign cfg_new   = (q_ff.bit_cnt <= SAC_CFG_LAST) ?
		{q_ff.cfg[SAC_CFG_BITS-2:0], q_ff.din_sync[1]} : q_ff.cfg;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_q           = q_ff;
		nxt_q.cs_sync   = {q_ff.cs_sync[0], cs_n_in};
		nxt_q.sclk_sync = {q_ff.sclk_sync[0], sclk_in};
		nxt_q.din_sync  = {q_ff.din_sync[0], din_in};
		nxt_q.aclk_sync = {q_ff.aclk_sync[0], aclk_in};
		nxt_q.sclk_prev = q_ff.sclk_sync[1];
		nxt_q.aclk_prev = q_ff.aclk_sync[1];
		nxt_q.aclk_fall = ~q_ff.aclk_sync[1] & q_ff.aclk_prev;
		nxt_q.start     = 1'b0;

		// deglitch on aclk falls; a blip between falls never counts
		if (q_ff.aclk_fall) begin
			if (q_ff.cs_sync[1] != q_ff.cs_rec) begin
				if (q_ff.dg_cnt == DG_LAST) begin
					nxt_q.cs_rec = q_ff.cs_sync[1];
					nxt_q.dg_cnt = 2'h0;
				end else begin
					nxt_q.dg_cnt = q_ff.dg_cnt + 2'h1;
				end
			end else begin
				nxt_q.dg_cnt = 2'h0;
			end
		end

		if (q_ff.cs_rec) begin
			// idle while select high, shift clock ignored
			nxt_q.loaded  = 1'b0;
			nxt_q.done    = 1'b0;
			nxt_q.bit_cnt = '0;
		end else if (!q_ff.loaded) begin
			// previous result, held back while still converting
			if (!cv.busy && !q_ff.done) begin
				nxt_q.out_sh = out_word(cv.result, q_ff.high_bit_first_select_next);
				nxt_q.loaded = 1'b1;
			end
		end else if (!q_ff.done) begin
			if (sclk_rise) begin
				nxt_q.cfg     = cfg_new;
				nxt_q.bit_cnt = cnt_new;
				if (q_ff.bit_cnt >= SAC_CFG_LAST &&
					cnt_new == word_len(cfg_new[SAC_CFG_WL_H:SAC_CFG_WL_L])) begin
					nxt_q.done      = 1'b1;
					nxt_q.start     = 1'b1;
					nxt_q.req       = cfg_new;
					nxt_q.high_bit_first_select_next = cfg_new[SAC_CFG_HIGH_BIT_FIRST_SELECT];
				end
			end else if (sclk_fall && q_ff.bit_cnt != '0) begin
				nxt_q.out_sh = {q_ff.out_sh[SAC_OUT_MAX-2:0], 1'b0};
			end
		end
	end

	// state register, synchronous reset to idle, select high
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			q_ff <= '{2'h3, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 2'h0,
				1'b0, 1'b0, '0, SAC_CFG_RST, SAC_CFG_RST, 1'b1,
				'0, 1'b0, 1'b0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	assign cv.start      = q_ff.start;
	assign cv.aclk_fall  = q_ff.aclk_fall;
	assign cv.coding_uni = q_ff.req[SAC_CFG_UNI];
	assign cv.code       = analog_code_in;

	sac_conv #(
		.CONV_CYCLES (CONV_CYCLES)
	) u_conv (
		.clock_in (clock_in),
		.nrst_in  (nrst_in),
		.cv       (cv)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dout_out    = q_ff.out_sh[SAC_OUT_MAX-1];
	assign dout_oe_out = ~q_ff.cs_rec & q_ff.loaded;

	// pair or single channel; positive end is the same
	assign pos_channel_out   = {q_ff.req[SAC_CFG_SEL_H:SAC_CFG_SEL_L],
		q_ff.req[SAC_CFG_ODD]};
	assign neg_channel_out   = {q_ff.req[SAC_CFG_SEL_H:SAC_CFG_SEL_L],
		~q_ff.req[SAC_CFG_ODD]};
	assign neg_is_common_out = q_ff.req[SAC_CFG_SGL];
	assign coding_select_out = q_ff.req[SAC_CFG_UNI];
	assign converting_out    = cv.busy;
endmodule

// [hw/sac_pkg.sv]
/*
 * Shared constants and types of the serial converter control port.
 * Assumes one system clock; the serial pins and conversion clock are synchronised inside the top.
 */
package sac_pkg;
	// ----------------------------------------------------------------
	// word sizes
	// ----------------------------------------------------------------
	localparam int unsigned SAC_CFG_BITS = 8;
	localparam int unsigned SAC_RES_BITS = 10;
	localparam int unsigned SAC_OUT_MAX  = 16;
	localparam int unsigned SAC_CNT_W    = 5;

	// configuration bit positions, first received bit is the top bit
	localparam int unsigned SAC_CFG_SGL   = 7;
	localparam int unsigned SAC_CFG_ODD   = 6;
	localparam int unsigned SAC_CFG_SEL_H = 5;
	localparam int unsigned SAC_CFG_SEL_L = 4;
	localparam int unsigned SAC_CFG_UNI   = 3;
	localparam int unsigned SAC_CFG_HIGH_BIT_FIRST_SELECT  = 2;
	localparam int unsigned SAC_CFG_WL_H  = 1;
	localparam int unsigned SAC_CFG_WL_L  = 0;

	// output word lengths per length code
	localparam logic [SAC_CNT_W-1:0] SAC_LEN_8  = 5'h08;
	localparam logic [SAC_CNT_W-1:0] SAC_LEN_10 = 5'h0a;
	localparam logic [SAC_CNT_W-1:0] SAC_LEN_12 = 5'h0c;
	localparam logic [SAC_CNT_W-1:0] SAC_LEN_16 = 5'h10;
	localparam logic [SAC_CNT_W-1:0] SAC_CFG_LAST = 5'h07;

	// ----------------------------------------------------------------
	// timing in conversion clock cycles
	// ----------------------------------------------------------------
	localparam int unsigned SAC_CONV_ACLK   = 44;
	localparam int unsigned SAC_DEGLITCH_FL = 2;

	// reset values
	localparam logic [SAC_CFG_BITS-1:0] SAC_CFG_RST = 8'h00;
	localparam logic [SAC_RES_BITS-1:0] SAC_RES_RST = 10'h000;

	typedef enum logic [0:0] {
		SAC_IDLE = 1'b0,
		SAC_BUSY = 1'b1
	} sac_conv_state_t;
endpackage

// [hw/sac_conv_if.sv]
/*
 * Carrier between the port logic and the conversion sequencer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface sac_conv_if;
	import sac_pkg::*;
	logic                    start;      // one-cycle conversion request
	logic                    aclk_fall;  // one-cycle conversion clock tick
	logic                    coding_uni; // 1 unipolar, 0 bipolar
	logic [SAC_RES_BITS-1:0] code;       // offset-binary code from core
	logic                    busy;
	logic [SAC_RES_BITS-1:0] result;

	modport ctl  (output start, aclk_fall, coding_uni, code,
		input busy, result);
	modport conv (input start, aclk_fall, coding_uni, code,
		output busy, result);
endinterface

// [hw/sac_conv.sv]
/*
 * Conversion sequencer: counts conversion clock ticks and codes result.
 * Assumes aclk_fall is already synchronised and one cycle wide.
 */
`timescale 1ns/1ps
module sac_conv
	import sac_pkg::*;
#(
	parameter int unsigned CONV_CYCLES = SAC_CONV_ACLK
) (
	// clock and reset
	input  wire logic clock_in,
	input  wire logic nrst_in,
	// port logic side
	sac_conv_if.conv  cv
);
	if (CONV_CYCLES < 1 || CONV_CYCLES > 63) begin : g_chk
		$error("sac_conv: CONV_CYCLES out of range");
	end

	localparam logic [5:0] LAST = 6'(CONV_CYCLES - 1);

	typedef struct packed {
		sac_conv_state_t         st;
		logic [5:0]              cnt;
		logic                    coding_select;
		logic [SAC_RES_BITS-1:0] result;
	} sac_conv_st_t;

	sac_conv_st_t q_ff;
	sac_conv_st_t nxt_q;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb begin
		nxt_q = q_ff;
		case (q_ff.st)
			SAC_IDLE: begin
				if (cv.start) begin
					nxt_q.st  = SAC_BUSY;
					nxt_q.cnt = 6'h00;
					nxt_q.coding_select = cv.coding_uni;
				end
			end
			SAC_BUSY: begin
				if (cv.aclk_fall) begin
					nxt_q.cnt = q_ff.cnt + 6'h01;
					if (q_ff.cnt == LAST) begin
						nxt_q.st = SAC_IDLE;
						nxt_q.result = q_ff.coding_select ? cv.code :
							{~cv.code[SAC_RES_BITS-1],
							cv.code[SAC_RES_BITS-2:0]};
					end
				end
			end
			default: nxt_q.st = SAC_IDLE;
		endcase
	end

	// state register, synchronous reset
	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			nxt_q_rst: q_ff <= '{SAC_IDLE, 6'h00, 1'b0, SAC_RES_RST};
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign cv.busy   = (q_ff.st == SAC_BUSY);
	assign cv.result = q_ff.result;
endmodule

// [sim/sac_chk.sv]
/* pin checker for the converter control port
 * assumes the conversion clock runs near five system clocks a period */
`timescale 1ns/1ps
module sac_chk
	import sac_pkg::*;
#(
	parameter int unsigned CONV_CYCLES	= SAC_CONV_ACLK,
	parameter int unsigned DEGLITCH_FALLS	= SAC_DEGLITCH_FL
) (
	// clock and reset
	input wire logic	clock_in,
	input wire logic	nrst_in,
	// serial pins
	input wire logic	cs_n_in,
	input wire logic	sclk_in,
	input wire logic	din_in,
	input wire logic	aclk_in,
	input wire logic	dout_out,
	input wire logic	dout_oe_out,
	// analog core
	input wire logic [SAC_RES_BITS-1:0]	analog_code_in,
	input wire logic [2:0]	pos_channel_out,
	input wire logic [2:0]	neg_channel_out,
	input wire logic	neg_is_common_out,
	input wire logic	coding_select_out,
	input wire logic	converting_out
);
	// --------------------------------------------------------------
	// helper counters
	// --------------------------------------------------------------
	localparam int CONV_MAX = 12 * CONV_CYCLES;
	localparam int CS_WAIT = 20;
	logic [7:0]	lo_ff;
	logic [7:0]	hi_ff;
	// saturating run lengths so each compare fires once per level
	always_ff @(posedge clock_in) begin
		lo_ff <= (!nrst_in || cs_n_in) ? 8'h00 : lo_ff + {7'h0, lo_ff != 8'hff};
		hi_ff <= (!nrst_in || !cs_n_in) ? 8'h00 : hi_ff + {7'h0, hi_ff != 8'hff};
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	sequence s_conv_hold;
		converting_out[*8];
	endsequence
	property p_oe_needs_cs;
		$rose(dout_oe_out) |-> !converting_out && !$past(cs_n_in, 3);
	endproperty
	a_oe_needs_cs: assert property (p_oe_needs_cs)
		else $error("output enabled without select");
	property p_oe_drops;
		hi_ff == CS_WAIT |-> !dout_oe_out;
	endproperty
	a_oe_drops: assert property (p_oe_drops)
		else $error("output still driven while deselected");
	property p_oe_rises;
		lo_ff == CS_WAIT && !converting_out |-> ##[0:2] dout_oe_out;
	endproperty
	a_oe_rises: assert property (p_oe_rises)
		else $error("select low not recognised");
	property p_conv_start;
		$rose(converting_out) |-> !cs_n_in && dout_oe_out;
	endproperty
	a_conv_start: assert property (p_conv_start)
		else $error("conversion outside a transfer");
	property p_conv_min;
		$rose(converting_out) |-> s_conv_hold;
	endproperty
	a_conv_min: assert property (p_conv_min)
		else $error("conversion too short");
	property p_conv_max;
		$rose(converting_out) |-> ##[1:CONV_MAX] !converting_out;
	endproperty
	a_conv_max: assert property (p_conv_max)
		else $error("conversion too long");
	property p_coding_upd;
		$changed(coding_select_out) |-> ##[0:2] converting_out;
	endproperty
	a_coding_upd: assert property (p_coding_upd)
		else $error("coding changed without a request");
	property p_chan_upd;
		$changed(pos_channel_out) |-> ##[0:2] converting_out;
	endproperty
	a_chan_upd: assert property (p_chan_upd)
		else $error("channel changed without a request");
	property p_dout_hold;
		$changed(dout_out) && $past(dout_oe_out) |-> !sclk_in;
	endproperty
	a_dout_hold: assert property (p_dout_hold)
		else $error("output bit changed while shift clock high");
endmodule
bind sac_top sac_chk #(.CONV_CYCLES(CONV_CYCLES),
	.DEGLITCH_FALLS(DEGLITCH_FALLS)) u_chk (.clock_in(clock_in),
	.nrst_in(nrst_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
	.din_in(din_in), .aclk_in(aclk_in), .dout_out(dout_out),
	.dout_oe_out(dout_oe_out), .analog_code_in(analog_code_in),
	.pos_channel_out(pos_channel_out), .neg_channel_out(neg_channel_out),
	.neg_is_common_out(neg_is_common_out),
	.coding_select_out(coding_select_out),
	.converting_out(converting_out));

// [sim/sac_host.sv]
/* host side of the serial link: select, shift clock and data in
 * assumes the bench calls its tasks just after a clock edge */
`timescale 1ns/1ps
module sac_host (
	// clock
	input wire logic	clock_in,
	// link pins
	output logic	cs_n_out,
	output logic	sclk_out,
	output logic	din_out,
	input wire logic	dout_in,
	input wire logic	dout_oe_in
);
	// shift clock rests low between frames
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		din_out = 1'b0;
	end
	// half a shift clock period, eight system clocks
	task automatic half();
		repeat (8) @(posedge clock_in);
		#1;
	endtask
	// select low, launch on fall, sample on rise
	task automatic xfer(input logic [7:0] cfg, input int nb,
		output logic [15:0] got, output logic ok);
		int w;
		got = 16'h0000;
		w = 0;
		cs_n_out = 1'b0;
		while (dout_oe_in !== 1'b1 && w < 200) begin
			half();
			w++;
		end
		ok = dout_oe_in;
		for (int i = 0; i < nb; i++) begin
			// bits past the eighth are junk the device drops
			din_out = (i < 8) ? cfg[7-i] : ~din_out;
			half();
			// a released line reads as the inverse of its last level
			got = {got[14:0], (dout_oe_in === 1'b1) ? dout_in : ~dout_in};
			sclk_out = 1'b1;
			half();
			sclk_out = 1'b0;
		end
		half();
		cs_n_out = 1'b1;
		din_out = ~din_out;
		repeat (4) half();
	endtask
	// select pulse far shorter than one conversion clock
	task automatic blip(input int n);
		cs_n_out = 1'b0;
		repeat (n) @(posedge clock_in);
		#1;
		cs_n_out = 1'b1;
	endtask
endmodule

// [sim/tb.sv]
/* self-checking bench of the converter control port
 * assumes the host model and the pin checker beside the design */
`timescale 1ns/1ps
module tb;
	import sac_pkg::*;
	logic	clock_in = 1'b0;
	logic	aclk_in = 1'b0;
	logic	nrst_in;
	logic	cs_n, sclk, din, dout_out, dout_oe_out;
	logic [9:0]	analog_code_in;
	logic [2:0]	pos_channel_out, neg_channel_out;
	logic	neg_is_common_out, coding_select_out, converting_out;
	int	miscompares = 0;
	int	tests_run = 0;
	// conversion clock unrelated in phase to the system clock
	always #4 clock_in = ~clock_in;
	always #20.3 aclk_in = ~aclk_in;
	sac_host u_host (.clock_in(clock_in), .cs_n_out(cs_n), .sclk_out(sclk),
		.din_out(din), .dout_in(dout_out), .dout_oe_in(dout_oe_out));
	// full-length conversion so that select can fall while one still runs
	sac_top #(.CONV_CYCLES(SAC_CONV_ACLK),
		.DEGLITCH_FALLS(SAC_DEGLITCH_FL)) u_dut (
		.clock_in(clock_in), .nrst_in(nrst_in), .cs_n_in(cs_n),
		.sclk_in(sclk), .din_in(din), .aclk_in(aclk_in),
		.dout_out(dout_out), .dout_oe_out(dout_oe_out),
		.analog_code_in(analog_code_in), .pos_channel_out(pos_channel_out),
		.neg_channel_out(neg_channel_out),
		.neg_is_common_out(neg_is_common_out),
		.coding_select_out(coding_select_out),
		.converting_out(converting_out));
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	function automatic int len_of(input logic [1:0] wl);
		return (wl == 2'b00) ? 8 : (wl == 2'b01) ? 10 : (wl == 2'b10) ? 12 : 16;
	endfunction
	// result bits in the chosen order, then zero padding
	function automatic logic [15:0] exp_word(input logic [9:0] r,
		input logic high_bit_first_select, input logic [1:0] wl);
		logic [15:0] w;
		w = 16'h0000;
		for (int i = 0; i < len_of(wl); i++)
			w = {w[14:0], (i < 10) ? (high_bit_first_select ? r[9-i] : r[i]) : 1'b0};
		return w;
	endfunction
	task automatic wait_idle();
		int w;
		w = 0;
		while (converting_out !== 1'b0 && w < 500) begin
			@(posedge clock_in);
			w++;
		end
		check(converting_out === 1'b0, "conversion hung");
	endtask
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		check(dout_oe_out === 1'b0 && converting_out === 1'b0, "idle");
		$display("test reset done");
	endtask
	task automatic t_glitch();
		u_host.blip(2);
		repeat (40) @(posedge clock_in);
		check(dout_oe_out === 1'b0 && converting_out === 1'b0, "blip");
		$display("test glitch done");
	endtask
	// every length, both orders, both codings, both input modes
	task automatic t_seq();
		logic [7:0] cfg [5] = '{8'hed, 8'h13, 8'h7c, 8'h82, 8'h0d};
		logic [9:0] code [5] = '{10'h2a5, 10'h123, 10'h3ff, 10'h001, 10'h200};
		logic [9:0] res;
		logic [7:0] c;
		logic [15:0] got;
		logic high_bit_first_select;
		logic ok;
		res = 10'h000;
		high_bit_first_select = 1'b1;
		for (int i = 0; i < 5; i++) begin
			c = cfg[i];
			analog_code_in = code[i];
			u_host.xfer(c, len_of(c[1:0]), got, ok);
			check(ok === 1'b1, "never enabled");
			check(got === exp_word(res, high_bit_first_select, c[1:0]), "word");
			check(pos_channel_out === {c[5:4], c[6]}, "pos");
			check(c[7] || neg_channel_out === {c[5:4], ~c[6]}, "neg");
			check(neg_is_common_out === c[7], "mode");
			check(coding_select_out === c[3], "coding");
			wait_idle();
			// straight binary or sign bit flipped
			res = c[3] ? code[i] : {~code[i][9], code[i][8:0]};
			high_bit_first_select = c[2];
		end
		$display("test sequence done");
	endtask
	task automatic t_abort();
		logic [15:0] got;
		logic ok;
		u_host.xfer(8'hf0, 4, got, ok);
		check(converting_out === 1'b0 && pos_channel_out === 3'h0, "abort");
		$display("test abort done");
	endtask
	// select falls again while converting: the word waits for the result
	task automatic t_early();
		logic [15:0] got;
		logic ok;
		analog_code_in = 10'h155;
		// stored word is still the last one of the sequence test
		u_host.xfer(8'h9a, 12, got, ok);
		check(got === exp_word(10'h200, 1'b1, 2'b10), "first word");
		check(converting_out === 1'b1, "not converting");
		u_host.xfer(8'h6c, 8, got, ok);
		check(ok === 1'b1, "never enabled after conversion");
		check(got === exp_word(10'h155, 1'b0, 2'b00), "held result");
		wait_idle();
		$display("test early select done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		nrst_in = 1'b0;
		analog_code_in = 10'h000;
		repeat (3) @(posedge clock_in);
		#1;
		nrst_in = 1'b1;
		repeat (4) @(posedge clock_in);
		#1;
		t_reset();
		t_glitch();
		t_seq();
		t_abort();
		t_early();
		report_and_stop();
	end
	// watchdog well beyond the few tens of microseconds needed
	initial begin
		#200000;
		miscompares++;
		$display("mismatch at %0t: watchdog", $time);
		report_and_stop();
	end
endmodule
